// ===== inc/urx_defines.svh
// Offsets, field positions, reset values and counts of the receive status
// Contract
// - Framing flag, bit 0, set when stop bit samples low.
// - Parity flag, bit 1, set when parity disagrees with chosen mode.
// - Break flag, bit 2, set when line low beyond one character time.
// - A break loads exactly one all-zero character into the FIFO.
// - After break, wait for line high and a fresh start bit.
// - Overrun flag, bit 3, set when character completes with FIFO full.
// - On overrun FIFO contents stay intact; only shift register is lost.
// - Any write to error-clear location clears all four flags.
// - In FIFO mode flags describe the character at the FIFO head.
// - Timeout interrupt when FIFO holds data and no character arrives.
// - Timeout interval bits 21:0, read-write, reset 0x1FF.
// - Interval counts oversample ticks: 16 per bit, or 8 when selected.
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH

`define URX_OFF_DATA 8'h00
`define URX_OFF_ERR 8'h04
`define URX_OFF_TOUT 8'h0C
`define URX_OFF_CTRL 8'h10
`define URX_OFF_ISTAT 8'h14
`define URX_OFF_IMASK 8'h18

`define URX_CTRL_PEN 0
`define URX_CTRL_EVEN 1
`define URX_CTRL_STICK 2
`define URX_CTRL_OVS 3
`define URX_CTRL_FEN 4
`define URX_CTRL_RST 32'h0004_0010

`define URX_W_FRM 8
`define URX_W_PAR 9
`define URX_W_BRK 10
`define URX_ERR_OVR 3

`define URX_INT_RX 0
`define URX_INT_TOUT 1
`define URX_INT_FRM 2
`define URX_INT_PAR 3
`define URX_INT_BRK 4
`define URX_INT_OE 5

`define URX_TOUT_W 22
`define URX_TOUT_RST 22'h01FF

`define URX_LAST_X16 4'hF
`define URX_LAST_X8 4'h7
`define URX_HALF_X16 4'h7
`define URX_HALF_X8 4'h3

`endif

// ===== inc/urx_pkg.sv
// Types of the receive status block
package urx_pkg;
   typedef logic [10:0] urx_word_type;
   typedef enum logic [5:0] {
      RX_IDLE = 6'h01,
      RX_START = 6'h02,
      RX_DATA = 6'h04,
      RX_PAR = 6'h08,
      RX_STOP = 6'h10,
      RX_BRK = 6'h20
   } urx_state_type;
endpackage : urx_pkg

// ===== inc/urx_link_if.sv
// Character path between receiver, FIFO and control core
`timescale 1ns/1ns
interface urx_link_if;
   logic valid;
   urx_pkg::urx_word_type word;
   logic pop;
   logic one_deep;
   logic full;
   logic empty;
   urx_pkg::urx_word_type head;
   modport src (output valid, output word);
   modport fifo (input valid, input word, input pop, input one_deep,
      output full, output empty, output head);
endinterface : urx_link_if

// ===== logic/urx_rx_fifo.sv
// Receive FIFO holding characters with their error bits
`timescale 1ns/1ns
module urx_rx_fifo #(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   urx_link_if.fifo link
);
   urx_pkg::urx_word_type mem [DEPTH];
   urx_pkg::urx_word_type next_mem [DEPTH];
   logic [AW-1:0] wp, next_wp, rp, next_rp;
   logic [AW:0] cnt, next_cnt;
   logic push, pop;

   assign link.full = link.one_deep ? (cnt != '0) : (cnt == (AW+1)'(DEPTH));
   assign link.empty = (cnt == '0);
   assign link.head = mem[rp];
   assign push = link.valid & !link.full;
   assign pop = link.pop & !link.empty;

   always_comb begin
      next_mem = mem;
      next_wp = wp;
      next_rp = rp;
      next_cnt = cnt;
      if (push) begin
         next_mem[wp] = link.word;
         next_wp = (wp == AW'(DEPTH - 1)) ? '0 : AW'(wp + 1'b1);
      end
      if (pop) begin
         next_rp = (rp == AW'(DEPTH - 1)) ? '0 : AW'(rp + 1'b1);
      end
      if (push & !pop) begin
         next_cnt = (AW+1)'(cnt + 1'b1);
      end else if (pop & !push) begin
         next_cnt = (AW+1)'(cnt - 1'b1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         mem <= next_mem;
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
   end

   a_ovr_keep: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (link.valid & link.full & !link.pop) |=> ($stable(cnt) && $stable(wp))
   ) else $error("FIFO written while full");
endmodule : urx_rx_fifo

// ===== logic/urx_rx_deser.sv
// Serial receiver: start detect, data, parity, stop and break
`timescale 1ns/1ns
`include "urx_defines.svh"

module urx_rx_deser (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic rxd_i,
   input wire logic ovs_sel_i,
   input wire logic par_en_i,
   input wire logic par_even_i,
   input wire logic par_stick_i,
   urx_link_if.src link
);
   urx_pkg::urx_state_type phase, next_phase;
   logic [3:0] tc, next_tc, bc, next_bc;
   logic [7:0] sh, next_sh;
   logic pbit, next_pbit, low, next_low, perr;
   logic [3:0] last, half;

   assign last = ovs_sel_i ? `URX_LAST_X8 : `URX_LAST_X16;
   assign half = ovs_sel_i ? `URX_HALF_X8 : `URX_HALF_X16;
   // Stick parity fixes the bit; else even or odd sum over data
   assign perr = par_en_i & (par_stick_i ? (pbit == par_even_i)
      : (^sh ^ pbit ^ !par_even_i));

   always_comb begin
      next_phase = phase;
      next_tc = tc;
      next_bc = bc;
      next_sh = sh;
      next_pbit = pbit;
      next_low = low;
      link.valid = 1'b0;
      link.word = '0;
      case (phase)
         urx_pkg::RX_IDLE: begin
            next_tc = '0;
            if (tick_i & !rxd_i) begin
               next_phase = urx_pkg::RX_START;
            end
         end
         urx_pkg::RX_START: begin
            if (tick_i) begin
               next_tc = 4'(tc + 1'b1);
               if (tc == half) begin
                  next_tc = '0;
                  next_bc = '0;
                  next_low = 1'b1;
                  next_pbit = 1'b0;
                  next_phase = rxd_i ? urx_pkg::RX_IDLE : urx_pkg::RX_DATA;
               end
            end
         end
         urx_pkg::RX_DATA: begin
            if (tick_i) begin
               next_tc = 4'(tc + 1'b1);
               if (tc == last) begin
                  next_tc = '0;
                  next_sh = {rxd_i, sh[7:1]};
                  next_low = low & !rxd_i;
                  next_bc = 4'(bc + 1'b1);
                  if (bc == 4'h7) begin
                     next_phase = par_en_i ? urx_pkg::RX_PAR
                        : urx_pkg::RX_STOP;
                  end
               end
            end
         end
         urx_pkg::RX_PAR: begin
            if (tick_i) begin
               next_tc = 4'(tc + 1'b1);
               if (tc == last) begin
                  next_tc = '0;
                  next_pbit = rxd_i;
                  next_low = low & !rxd_i;
                  next_phase = urx_pkg::RX_STOP;
               end
            end
         end
         urx_pkg::RX_STOP: begin
            if (tick_i) begin
               next_tc = 4'(tc + 1'b1);
               if (tc == last) begin
                  link.valid = 1'b1;
                  if (low & !rxd_i) begin
                     link.word[`URX_W_BRK] = 1'b1;
                     next_phase = urx_pkg::RX_BRK;
                  end else begin
                     link.word[7:0] = sh;
                     link.word[`URX_W_FRM] = !rxd_i;
                     link.word[`URX_W_PAR] = perr;
                     next_phase = urx_pkg::RX_IDLE;
                  end
               end
            end
         end
         urx_pkg::RX_BRK: begin
            if (rxd_i) begin
               next_phase = urx_pkg::RX_IDLE;
            end
         end
         default: begin
            next_phase = urx_pkg::RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase <= urx_pkg::RX_IDLE;
         tc <= '0;
         bc <= '0;
         sh <= '0;
         pbit <= 1'b0;
         low <= 1'b0;
      end else begin
         phase <= next_phase;
         tc <= next_tc;
         bc <= next_bc;
         sh <= next_sh;
         pbit <= next_pbit;
         low <= next_low;
      end
   end

   a_brk_hold: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (phase == urx_pkg::RX_BRK && !rxd_i)
         |=> (phase == urx_pkg::RX_BRK) && !link.valid
   ) else $error("Receiver left break state while line low");

   a_brk_once: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (link.valid && link.word[`URX_W_BRK]) |-> (link.word[7:0] == 8'h00)
         ##1 (phase == urx_pkg::RX_BRK)
   ) else $error("Break character not single and zero");
endmodule : urx_rx_deser

// ===== logic/urx_rx_status.sv
// Top: register port, error status, timeout and interrupt of receive path
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "urx_defines.svh"

module urx_rx_status #(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic RXD_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   output logic IRQ_O
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   urx_link_if link ();
   logic [31:0] ctrl, next_ctrl;
   logic [`URX_TOUT_W-1:0] tout, next_tout;
   logic [5:0] imask, next_imask;
   logic [5:0] istat, next_istat;
   logic hide, next_hide;
   logic oe, next_oe;
   logic [31:0] next_rdata;
   logic next_irq;
   logic [15:0] bcnt, next_bcnt;
   logic tick, next_tick;
   logic [`URX_TOUT_W-1:0] tcount, next_tcount;
   logic fired, next_fired;
   logic tout_ev;
   logic err_clr, push, ovr;
   logic [3:0] err_val;
   logic [5:0] ev;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // ----------------------------------------------------------------
   // Receiver and FIFO
   // ----------------------------------------------------------------
   urx_rx_deser u_deser (
      .clk_i(REF_CLK_I),
      .rst_n_i(RST_N_I),
      .tick_i(tick),
      .rxd_i(RXD_I),
      .ovs_sel_i(ctrl[`URX_CTRL_OVS]),
      .par_en_i(ctrl[`URX_CTRL_PEN]),
      .par_even_i(ctrl[`URX_CTRL_EVEN]),
      .par_stick_i(ctrl[`URX_CTRL_STICK]),
      .link(link.src)
   );

   urx_rx_fifo #(
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_fifo (
      .clk_i(REF_CLK_I),
      .rst_n_i(RST_N_I),
      .link(link.fifo)
   );

   assign link.pop = RD_I & hit(ADDR_I, `URX_OFF_DATA) & !link.empty;
   assign link.one_deep = !ctrl[`URX_CTRL_FEN];
   assign push = link.valid & !link.full;
   assign ovr = link.valid & link.full;
   assign err_clr = WR_I & hit(ADDR_I, `URX_OFF_ERR);

   // Head flags shown unless cleared since this head arrived
   assign err_val[2:0] = (hide | link.empty) ? 3'h0
      : link.head[`URX_W_BRK:`URX_W_FRM];
   assign err_val[`URX_ERR_OVR] = oe;

   // ----------------------------------------------------------------
   // Oversample tick
   // ----------------------------------------------------------------
   always_comb begin
      next_bcnt = 16'(bcnt + 16'h0001);
      next_tick = 1'b0;
      if (16'(bcnt + 16'h0001) >= ctrl[31:16]) begin
         next_bcnt = 16'h0000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         bcnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         bcnt <= next_bcnt;
         tick <= next_tick;
      end
   end

   // ----------------------------------------------------------------
   // Receive timeout
   // ----------------------------------------------------------------
   always_comb begin
      next_tcount = tcount;
      next_fired = fired;
      tout_ev = 1'b0;
      if (link.empty | push) begin
         next_tcount = '0;
         next_fired = 1'b0;
      end else if (tick & !fired) begin
         next_tcount = `URX_TOUT_W'(tcount + 1'b1);
         if (`URX_TOUT_W'(tcount + 1'b1) >= tout) begin
            tout_ev = 1'b1;
            next_fired = 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tcount <= '0;
         fired <= 1'b0;
      end else begin
         tcount <= next_tcount;
         fired <= next_fired;
      end
   end

   // ----------------------------------------------------------------
   // Registers, status and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      ev = 6'h00;
      ev[`URX_INT_RX] = push;
      ev[`URX_INT_TOUT] = tout_ev;
      ev[`URX_INT_FRM] = push & link.word[`URX_W_FRM];
      ev[`URX_INT_PAR] = push & link.word[`URX_W_PAR];
      ev[`URX_INT_BRK] = push & link.word[`URX_W_BRK];
      ev[`URX_INT_OE] = ovr;
      next_ctrl = ctrl;
      next_tout = tout;
      next_imask = imask;
      next_istat = istat;
      next_hide = hide;
      next_oe = oe;
      next_rdata = 32'h0000_0000;
      if (WR_I) begin
         if (hit(ADDR_I, `URX_OFF_CTRL)) begin
            next_ctrl = WDATA_I;
         end
         if (hit(ADDR_I, `URX_OFF_TOUT)) begin
            next_tout = WDATA_I[`URX_TOUT_W-1:0];
         end
         if (hit(ADDR_I, `URX_OFF_IMASK)) begin
            next_imask = WDATA_I[5:0];
         end
      end
      if (err_clr) begin
         next_hide = 1'b1;
         next_oe = 1'b0;
      end
      // A new head character shows its own flags again
      if (link.pop | (push & link.empty)) begin
         next_hide = 1'b0;
      end
      if (ovr) begin
         next_oe = 1'b1;
      end
      if (RD_I) begin
         if (hit(ADDR_I, `URX_OFF_DATA)) begin
            next_rdata = {20'h0_0000, oe, link.head};
         end
         if (hit(ADDR_I, `URX_OFF_ERR)) begin
            next_rdata = {28'h000_0000, err_val};
         end
         if (hit(ADDR_I, `URX_OFF_TOUT)) begin
            next_rdata = {10'h000, tout};
         end
         if (hit(ADDR_I, `URX_OFF_CTRL)) begin
            next_rdata = ctrl;
         end
         if (hit(ADDR_I, `URX_OFF_ISTAT)) begin
            next_rdata = {26'h000_0000, istat};
            next_istat = 6'h00;
         end
         if (hit(ADDR_I, `URX_OFF_IMASK)) begin
            next_rdata = {26'h000_0000, imask};
         end
      end
      next_istat = next_istat | ev;
      next_irq = |(next_istat & next_imask);
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctrl <= `URX_CTRL_RST;
         tout <= `URX_TOUT_RST;
         imask <= 6'h00;
         istat <= 6'h00;
         hide <= 1'b0;
         oe <= 1'b0;
         RDATA_O <= 32'h0000_0000;
         IRQ_O <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         tout <= next_tout;
         imask <= next_imask;
         istat <= next_istat;
         hide <= next_hide;
         oe <= next_oe;
         RDATA_O <= next_rdata;
         IRQ_O <= next_irq;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_frame_flag: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (push && link.empty && link.word[`URX_W_FRM] && !err_clr)
         |=> err_val[0]
   ) else $error("Framing flag not shown for head character");

   a_parity_flag: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (push && link.empty && link.word[`URX_W_PAR] && !err_clr)
         |=> err_val[1]
   ) else $error("Parity flag not shown for head character");

   a_break_flag: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (push && link.empty && link.word[`URX_W_BRK] && !err_clr)
         |=> err_val[2] && (link.head[7:0] == 8'h00)
   ) else $error("Break flag not shown for head character");

   a_ovr_flag: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      ovr |=> oe && istat[`URX_INT_OE]
   ) else $error("Overrun flag not set");

   a_err_clear: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (err_clr && !link.valid) |=> (err_val == 4'h0)
   ) else $error("Error clear left a flag set");

   a_head_flags: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (!link.empty && !hide) |-> (err_val[2:0] == link.head[10:8])
   ) else $error("Status does not follow head character");

   a_tout_fire: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (tick && !link.empty && !push && !fired
         && (`URX_TOUT_W'(tcount + 1'b1) >= tout))
         |=> istat[`URX_INT_TOUT] && fired
   ) else $error("Timeout did not fire");

   a_tout_write: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (WR_I && hit(ADDR_I, `URX_OFF_TOUT))
         |=> (tout == $past(WDATA_I[`URX_TOUT_W-1:0]))
   ) else $error("Timeout interval not written");

   a_tout_tick: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (!tick && !link.empty && !push) |=> $stable(tcount)
   ) else $error("Timeout counted without oversample tick");

   a_tout_restart: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (link.empty || push) |=> (tcount == '0) && !fired
   ) else $error("Timeout counter not restarted");

   a_rsvd_zero: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (RD_I && (hit(ADDR_I, `URX_OFF_TOUT) || hit(ADDR_I, `URX_OFF_ERR)))
         |=> (RDATA_O[31:22] == 10'h000) && (RDATA_O[21:4] == tout[21:4]
         || hit($past(ADDR_I), `URX_OFF_ERR))
   ) else $error("Reserved bits read nonzero");

   a_irq_level: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      ##1 (IRQ_O == |(istat & imask))
   ) else $error("Interrupt output disagrees with status");
endmodule : urx_rx_status

// ===== test/urx_line_model.sv
// Remote serial transmitter that drives the receive line
`timescale 1ns/1ns
module urx_line_model (
   input wire logic clk_i,
   output logic rxd_o
);
   // ----------------------------------------
   // Line timing
   // ----------------------------------------
   int bit_clks = 16;

   initial rxd_o = 1'b1;

   // Drive one level for n clocks, changed just after an edge
   task automatic hold(input logic v, input int n);
      rxd_o <= v;
      repeat (n) @(posedge clk_i);
   endtask : hold

   // Start, 8 data bits LSB first, even parity, stop, idle gap
   task automatic send(input logic [7:0] d, input logic par_bad,
         input logic stop_bad);
      @(posedge clk_i);
      hold(1'b0, bit_clks);
      for (int i = 0; i < 8; i++) begin
         hold(d[i], bit_clks);
      end
      hold((^d) ^ par_bad, bit_clks);
      hold(~stop_bad, bit_clks);
      hold(1'b1, bit_clks);
   endtask : send

   // Line low for n clocks, then back to marking
   task automatic brk(input int n);
      @(posedge clk_i);
      hold(1'b0, n);
      hold(1'b1, 2 * bit_clks);
   endtask : brk
endmodule : urx_line_model

// ===== test/uart_rx_error_status_timeout_tb.sv
// Self-checking bench of the receive error status and timeout block
`timescale 1ns/1ns
module uart_rx_error_status_timeout_tb;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   localparam logic [31:0] FULL = 32'hFFFF_FFFF;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rxd;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic irq;
   int failures = 0;
   int num_checks = 0;

   always #50 clk = ~clk;

   urx_line_model link_tx (.clk_i(clk), .rxd_o(rxd));

   urx_rx_status #(.DEPTH(4), .AW(2)) dut (
      .REF_CLK_I(clk),
      .RST_N_I(rst_n),
      .RXD_I(rxd),
      .ADDR_I(addr),
      .WDATA_I(wdata),
      .WR_I(wr),
      .RD_I(rd),
      .RDATA_O(rdata),
      .IRQ_O(irq)
   );

   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask : chk_rd

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk({31'h0, irq}, 32'h0);
      chk_rd(8'h04, FULL, 32'h0);
      chk_rd(8'h0C, FULL, 32'h0000_01FF);
      chk_rd(8'h08, FULL, 32'h0);
      wr_reg(8'h0C, FULL);
      chk_rd(8'h0C, FULL, 32'h003F_FFFF);
      wr_reg(8'h04, FULL);
      chk_rd(8'h04, FULL, 32'h0);
   endtask : t_reset

   task automatic t_errors;
      wr_reg(8'h10, 32'h0001_0013);
      link_tx.send(8'hA5, 1'b0, 1'b1);
      chk_rd(8'h04, FULL, 32'h1);
      wr_reg(8'h04, 32'h0);
      chk_rd(8'h04, FULL, 32'h0);
      chk_rd(8'h00, 32'hFF, 32'hA5);
      link_tx.send(8'h3C, 1'b0, 1'b0);
      link_tx.send(8'h81, 1'b1, 1'b0);
      chk_rd(8'h04, FULL, 32'h0);
      chk_rd(8'h00, FULL, 32'h3C);
      chk_rd(8'h04, FULL, 32'h2);
      chk_rd(8'h00, FULL, 32'h281);
   endtask : t_errors

   task automatic t_break;
      link_tx.brk(11 * 16 * 3);
      chk_rd(8'h04, FULL, 32'h4);
      link_tx.send(8'h42, 1'b0, 1'b0);
      chk_rd(8'h00, FULL, 32'h400);
      chk_rd(8'h00, FULL, 32'h42);
   endtask : t_break

   task automatic t_overrun;
      for (int i = 0; i < 5; i++) begin
         link_tx.send(8'h10 + i[7:0], 1'b0, 1'b0);
      end
      chk_rd(8'h04, FULL, 32'h8);
      for (int i = 0; i < 4; i++) begin
         chk_rd(8'h00, 32'hFF, 32'h10 + i);
      end
      link_tx.send(8'h66, 1'b0, 1'b0);
      chk_rd(8'h00, 32'hFF, 32'h66);
      wr_reg(8'h04, FULL);
      chk_rd(8'h04, FULL, 32'h0);
   endtask : t_overrun

   task automatic t_timeout;
      int n;
      n = 0;
      chk({31'h0, irq}, 32'h0);
      wr_reg(8'h10, 32'h0001_001B);
      link_tx.bit_clks = 8;
      wr_reg(8'h0C, 32'h0000_0028);
      chk_rd(8'h14, FULL, 32'h0000_003D);
      wr_reg(8'h18, 32'h0000_0002);
      link_tx.send(8'h5A, 1'b0, 1'b0);
      #1;
      chk({31'h0, irq}, 32'h0);
      while (irq !== 1'b1 && n < 80) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({31'h0, (n >= 28 && n <= 30)}, 32'h1);
      chk_rd(8'h14, FULL, 32'h3);
      wr_reg(8'h18, 32'h0);
      chk_rd(8'h00, FULL, 32'h5A);
   endtask : t_timeout

   task automatic t_onedeep;
      wr_reg(8'h10, 32'h0001_000D);
      link_tx.send(8'h01, 1'b0, 1'b0);
      link_tx.send(8'h03, 1'b0, 1'b0);
      chk_rd(8'h04, FULL, 32'h8);
      chk_rd(8'h00, FULL, 32'h801);
      wr_reg(8'h04, 32'h0);
      link_tx.send(8'h03, 1'b0, 1'b0);
      chk_rd(8'h04, FULL, 32'h2);
      chk_rd(8'h00, FULL, 32'h203);
   endtask : t_onedeep

   // ----------------------------------------
   // Verdict and run control
   // ----------------------------------------
   task automatic conclude;
      $display("Checks %0d, failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   initial begin
      #3_000_000;
      failures++;
      conclude();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_errors();
      t_break();
      t_overrun();
      t_timeout();
      t_onedeep();
      conclude();
   end
endmodule : uart_rx_error_status_timeout_tb
